// ==== rtl/scan_instruction_decoder.sv ====
// scan port state machine, instruction register and instruction decode
`timescale 1ns/1ps
`default_nettype none
module scan_instruction_decoder #(
  parameter logic [31:0] ID_CODE = 32'h1234_5001  // value arbitrary
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // scan pins
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  // configuration status
  input  wire logic        cfg_busy_i,
  input  wire logic        cfg_done_i,
  input  wire logic        startup_clock_source_i,
  // chain data
  input  wire logic [31:0] usercode_i,
  input  wire logic        bscan_tdo_i,
  input  wire logic        user_tdo_i,
  // decoded selects
  output logic             extest_o,
  output logic             sample_o,
  output logic             intest_o,
  output logic             highz_o,
  output logic             user_scan_instr_a_o,
  output logic             user_scan_instr_b_o,
  output logic             startup_step_o,
  // user register state outputs
  output logic             user_reset_o,
  output logic             user_update_o,
  output logic             user_shift_o
);
  scan_pin_if pins ();

  scan_pin_sync #(
    .STAGES (scan_decode_pkg::SYNC_W)
  ) u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .tck_i  (tck_i),
    .tms_i  (tms_i),
    .tdi_i  (tdi_i),
    .pins   (pins)
  );

  scan_decode_pkg::tap_state_t state_q;
  scan_decode_pkg::tap_state_t state_d;
  scan_decode_pkg::instr_t     ir_q;
  scan_decode_pkg::instr_t     ir_d;
  scan_decode_pkg::instr_t     ir_sh_q;
  scan_decode_pkg::instr_t     ir_sh_d;
  scan_decode_pkg::instr_t     eff;
  logic [31:0]                 id_sh_q;
  logic [31:0]                 id_sh_d;
  logic [31:0]                 uc_sh_q;
  logic [31:0]                 uc_sh_d;
  logic                        byp_q;
  logic                        byp_d;
  logic                        is_public;
  logic                        legal;
  logic                        dr_bit;
  logic [9:0]                  out_d;
  logic [9:0]                  out_q;
  logic                        tdo_d;
  logic                        tdo_oe_d;

  // port state machine on scan clock rise
  always_comb begin
    state_d = state_q;
    if (pins.tck_rise) begin
      case (state_q)
        scan_decode_pkg::ST_TLR:    state_d = pins.tms ? scan_decode_pkg::ST_TLR
                                                       : scan_decode_pkg::ST_RTI;
        scan_decode_pkg::ST_RTI:    state_d = pins.tms ? scan_decode_pkg::ST_SEL_DR
                                                       : scan_decode_pkg::ST_RTI;
        scan_decode_pkg::ST_SEL_DR: state_d = pins.tms ? scan_decode_pkg::ST_SEL_IR
                                                       : scan_decode_pkg::ST_CAP_DR;
        scan_decode_pkg::ST_CAP_DR: state_d = pins.tms ? scan_decode_pkg::ST_EX1_DR
                                                       : scan_decode_pkg::ST_SH_DR;
        scan_decode_pkg::ST_SH_DR:  state_d = pins.tms ? scan_decode_pkg::ST_EX1_DR
                                                       : scan_decode_pkg::ST_SH_DR;
        scan_decode_pkg::ST_EX1_DR: state_d = pins.tms ? scan_decode_pkg::ST_UPD_DR
                                                       : scan_decode_pkg::ST_PA_DR;
        scan_decode_pkg::ST_PA_DR:  state_d = pins.tms ? scan_decode_pkg::ST_EX2_DR
                                                       : scan_decode_pkg::ST_PA_DR;
        scan_decode_pkg::ST_EX2_DR: state_d = pins.tms ? scan_decode_pkg::ST_UPD_DR
                                                       : scan_decode_pkg::ST_SH_DR;
        scan_decode_pkg::ST_UPD_DR: state_d = pins.tms ? scan_decode_pkg::ST_SEL_DR
                                                       : scan_decode_pkg::ST_RTI;
        scan_decode_pkg::ST_SEL_IR: state_d = pins.tms ? scan_decode_pkg::ST_TLR
                                                       : scan_decode_pkg::ST_CAP_IR;
        scan_decode_pkg::ST_CAP_IR: state_d = pins.tms ? scan_decode_pkg::ST_EX1_IR
                                                       : scan_decode_pkg::ST_SH_IR;
        scan_decode_pkg::ST_SH_IR:  state_d = pins.tms ? scan_decode_pkg::ST_EX1_IR
                                                       : scan_decode_pkg::ST_SH_IR;
        scan_decode_pkg::ST_EX1_IR: state_d = pins.tms ? scan_decode_pkg::ST_UPD_IR
                                                       : scan_decode_pkg::ST_PA_IR;
        scan_decode_pkg::ST_PA_IR:  state_d = pins.tms ? scan_decode_pkg::ST_EX2_IR
                                                       : scan_decode_pkg::ST_PA_IR;
        scan_decode_pkg::ST_EX2_IR: state_d = pins.tms ? scan_decode_pkg::ST_UPD_IR
                                                       : scan_decode_pkg::ST_SH_IR;
        scan_decode_pkg::ST_UPD_IR: state_d = pins.tms ? scan_decode_pkg::ST_SEL_DR
                                                       : scan_decode_pkg::ST_RTI;
        default:                    state_d = scan_decode_pkg::ST_TLR;
      endcase
    end
  end

  // legality of the held instruction
  always_comb begin
    is_public = (ir_q == scan_decode_pkg::EXTEST_CODE)
             || (ir_q == scan_decode_pkg::SAMPLE_CODE)
             || (ir_q == scan_decode_pkg::INTEST_CODE)
             || (ir_q == scan_decode_pkg::USERCODE_CODE)
             || (ir_q == scan_decode_pkg::IDCODE_CODE)
             || (ir_q == scan_decode_pkg::HIGHZ_CODE)
             || (ir_q == scan_decode_pkg::STARTUP_CLOCK_INSTR)
             || (ir_q == scan_decode_pkg::BYPASS_CODE);
    if (cfg_busy_i) begin
      legal = (ir_q == scan_decode_pkg::SAMPLE_CODE)
           || (ir_q == scan_decode_pkg::BYPASS_CODE);
    end else if ((ir_q == scan_decode_pkg::USER_SCAN_A_CODE)
              || (ir_q == scan_decode_pkg::USER_SCAN_B_CODE)) begin
      legal = cfg_done_i;
    end else begin
      legal = is_public;
    end
    eff = legal ? ir_q : scan_decode_pkg::BYPASS_CODE;
  end

  // instruction and data registers, tdo
  always_comb begin
    ir_d     = ir_q;
    ir_sh_d  = ir_sh_q;
    id_sh_d  = id_sh_q;
    uc_sh_d  = uc_sh_q;
    byp_d    = byp_q;
    tdo_d    = tdo_o;
    tdo_oe_d = tdo_oe_o;
    case (eff)
      scan_decode_pkg::USERCODE_CODE: dr_bit = uc_sh_q[0];
      scan_decode_pkg::IDCODE_CODE:   dr_bit = id_sh_q[0];
      scan_decode_pkg::EXTEST_CODE,
      scan_decode_pkg::SAMPLE_CODE,
      scan_decode_pkg::INTEST_CODE:   dr_bit = bscan_tdo_i;
      scan_decode_pkg::USER_SCAN_A_CODE,
      scan_decode_pkg::USER_SCAN_B_CODE: dr_bit = user_tdo_i;
      default:                        dr_bit = byp_q;
    endcase
    if (pins.tck_rise) begin
      if (state_q == scan_decode_pkg::ST_CAP_IR) begin
        ir_sh_d = scan_decode_pkg::IR_CAPTURE_VAL;
      end else if (state_q == scan_decode_pkg::ST_SH_IR) begin
        ir_sh_d = {pins.tdi, ir_sh_q[scan_decode_pkg::IR_W-1:1]};
      end else if (state_q == scan_decode_pkg::ST_CAP_DR) begin
        id_sh_d = ID_CODE;
        uc_sh_d = usercode_i;
        byp_d   = 1'b0;
      end else if (state_q == scan_decode_pkg::ST_SH_DR) begin
        id_sh_d = {pins.tdi, id_sh_q[scan_decode_pkg::DR_W-1:1]};
        uc_sh_d = {pins.tdi, uc_sh_q[scan_decode_pkg::DR_W-1:1]};
        byp_d   = pins.tdi;
      end
    end
    if (pins.tck_fall) begin
      tdo_oe_d = (state_q == scan_decode_pkg::ST_SH_IR)
              || (state_q == scan_decode_pkg::ST_SH_DR);
      tdo_d    = (state_q == scan_decode_pkg::ST_SH_IR) ? ir_sh_q[0] : dr_bit;
      if (state_q == scan_decode_pkg::ST_UPD_IR) begin
        ir_d = ir_sh_q;
      end
    end
    if (state_q == scan_decode_pkg::ST_TLR) begin
      ir_d = scan_decode_pkg::IDCODE_CODE;
    end
  end

  // registered selects and state mirrors
  always_comb begin
    out_d[0] = (eff == scan_decode_pkg::EXTEST_CODE);
    out_d[1] = (eff == scan_decode_pkg::SAMPLE_CODE);
    out_d[2] = (eff == scan_decode_pkg::INTEST_CODE);
    out_d[3] = (eff == scan_decode_pkg::HIGHZ_CODE);
    out_d[4] = (eff == scan_decode_pkg::USER_SCAN_A_CODE);
    out_d[5] = (eff == scan_decode_pkg::USER_SCAN_B_CODE);
    out_d[6] = pins.tck_rise && startup_clock_source_i
            && (eff == scan_decode_pkg::STARTUP_CLOCK_INSTR);
    out_d[7] = (state_q == scan_decode_pkg::ST_TLR);
    out_d[8] = (state_q == scan_decode_pkg::ST_UPD_DR);
    out_d[9] = (state_q == scan_decode_pkg::ST_SH_DR);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_q  <= scan_decode_pkg::ST_TLR;
      ir_q     <= scan_decode_pkg::IDCODE_CODE;
      ir_sh_q  <= scan_decode_pkg::IR_CAPTURE_VAL;
      id_sh_q  <= scan_decode_pkg::DR_ZERO;
      uc_sh_q  <= scan_decode_pkg::DR_ZERO;
      byp_q    <= 1'b0;
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
      out_q    <= 10'h000;
    end else begin
      state_q  <= state_d;
      ir_q     <= ir_d;
      ir_sh_q  <= ir_sh_d;
      id_sh_q  <= id_sh_d;
      uc_sh_q  <= uc_sh_d;
      byp_q    <= byp_d;
      tdo_o    <= tdo_d;
      tdo_oe_o <= tdo_oe_d;
      out_q    <= out_d;
    end
  end

  assign extest_o            = out_q[0];
  assign sample_o            = out_q[1];
  assign intest_o            = out_q[2];
  assign highz_o             = out_q[3];
  assign user_scan_instr_a_o = out_q[4];
  assign user_scan_instr_b_o = out_q[5];
  assign startup_step_o      = out_q[6];
  assign user_reset_o        = out_q[7];
  assign user_update_o       = out_q[8];
  assign user_shift_o        = out_q[9];

  AST_INTEST_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ir_q == scan_decode_pkg::INTEST_CODE) && !cfg_busy_i |=> intest_o && !highz_o)
    else $error("internal test not selected");
  AST_USERCODE_OUT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pins.tck_fall && (state_q == scan_decode_pkg::ST_SH_DR)
    && (eff == scan_decode_pkg::USERCODE_CODE) |=> tdo_o == $past(uc_sh_q[0]) && tdo_oe_o)
    else $error("user code bit not on tdo");
  AST_IDCODE_CAP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pins.tck_rise && (state_q == scan_decode_pkg::ST_CAP_DR) |=> id_sh_q == ID_CODE)
    else $error("identification not captured");
  AST_HIGHZ_SEL: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (eff == scan_decode_pkg::HIGHZ_CODE) |=> highz_o && !intest_o && !extest_o)
    else $error("highz not selected");
  AST_STARTUP_STEP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pins.tck_rise && startup_clock_source_i && !cfg_busy_i
    && (ir_q == scan_decode_pkg::STARTUP_CLOCK_INSTR) |=> startup_step_o)
    else $error("start-up step missing");
  AST_STARTUP_HOLD: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(pins.tck_rise && startup_clock_source_i) |=> !startup_step_o)
    else $error("start-up step without scan clock");
  AST_USER_BLOCKED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !cfg_done_i && (ir_q == scan_decode_pkg::USER_SCAN_A_CODE) |=> !user_scan_instr_a_o)
    else $error("user instruction before configuration");
  AST_USER_ALLOWED: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cfg_done_i && !cfg_busy_i && (ir_q == scan_decode_pkg::USER_SCAN_B_CODE)
    |=> user_scan_instr_b_o)
    else $error("user instruction refused after configuration");
  AST_BUSY_LIMIT: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cfg_busy_i && (ir_q == scan_decode_pkg::SAMPLE_CODE) |=> sample_o && !intest_o)
    else $error("sample not honoured while busy");
  AST_SHIFT_MIRROR: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == scan_decode_pkg::ST_SH_DR) |=> user_shift_o && !user_reset_o)
    else $error("shift mirror wrong");
  AST_RESERVED_BYP: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !is_public && (ir_q != scan_decode_pkg::USER_SCAN_A_CODE)
    && (ir_q != scan_decode_pkg::USER_SCAN_B_CODE)
    |=> !(extest_o || sample_o || intest_o || highz_o || user_scan_instr_a_o
    || user_scan_instr_b_o))
    else $error("reserved code selected a chain");
  AST_BUSY_BYPASS: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cfg_busy_i && (ir_q != scan_decode_pkg::SAMPLE_CODE)
    |=> !(extest_o || sample_o || intest_o || highz_o || user_scan_instr_a_o
    || user_scan_instr_b_o))
    else $error("instruction honoured while busy");
endmodule // scan_instruction_decoder
`default_nettype wire

// ==== rtl/scan_decode_pkg.sv ====
// constants, codes and states of the scan instruction decoder
package scan_decode_pkg;
  localparam int IR_W      = 5;
  localparam int DR_W      = 32;
  localparam int SYNC_W    = 2;
  typedef logic [IR_W-1:0] instr_t;
  localparam instr_t EXTEST_CODE         = 5'h00;
  localparam instr_t SAMPLE_CODE         = 5'h01;
  localparam instr_t USER_SCAN_A_CODE    = 5'h02;
  localparam instr_t USER_SCAN_B_CODE    = 5'h03;
  localparam instr_t INTEST_CODE         = 5'h07;
  localparam instr_t USERCODE_CODE       = 5'h08;
  localparam instr_t IDCODE_CODE         = 5'h09;
  localparam instr_t HIGHZ_CODE          = 5'h0A;
  localparam instr_t STARTUP_CLOCK_INSTR = 5'h0C;
  localparam instr_t BYPASS_CODE         = 5'h1F;
  localparam instr_t IR_CAPTURE_VAL      = 5'h01;
  localparam logic [DR_W-1:0] DR_ZERO    = 32'h0000_0000;
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;
endpackage

// ==== rtl/scan_pin_if.sv ====
// synchronised scan pin events between pin sampler and decoder
`timescale 1ns/1ps
`default_nettype none
interface scan_pin_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  modport src (output tck_rise, output tck_fall, output tms, output tdi);
  modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface
`default_nettype wire

// ==== rtl/scan_pin_sync.sv ====
// two-stage sampler and edge finder for the scan pins
`timescale 1ns/1ps
`default_nettype none
module scan_pin_sync #(
  parameter int STAGES = scan_decode_pkg::SYNC_W
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // raw pins
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  // sampled events
  scan_pin_if.src   pins
);
  if (STAGES < 2) begin : g_chk
    $error("scan_pin_sync needs at least two stages");
  end

  logic [2:0] stage_q [STAGES];
  logic [2:0] stage_d [STAGES];
  logic       tck_prev_q;
  logic       tck_prev_d;

  // shift pins through the stages
  always_comb begin
    stage_d[0] = {tck_i, tms_i, tdi_i};
    for (int i = 1; i < STAGES; i++) begin
      stage_d[i] = stage_q[i-1];
    end
    tck_prev_d = stage_q[STAGES-1][2];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= 3'h0;
      end
      tck_prev_q <= 1'b0;
    end else begin
      stage_q    <= stage_d;
      tck_prev_q <= tck_prev_d;
    end
  end

  assign pins.tck_rise = stage_q[STAGES-1][2] & ~tck_prev_q;
  assign pins.tck_fall = ~stage_q[STAGES-1][2] & tck_prev_q;
  assign pins.tms      = stage_q[STAGES-1][1];
  assign pins.tdi      = stage_q[STAGES-1][0];
endmodule // scan_pin_sync
`default_nettype wire

// ==== verification/scan_tester.sv ====
// scan port tester model driving the pins of the decoder
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
  // scan pins
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  input  wire logic tdo_i
);
  // scan clock stands low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one scan clock, tdo taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #80;
    tdo = tdo_i;
    tck_o = 1'b1;
    #80;
    tck_o = 1'b0;
  endtask
  // state move, unused data line keeps changing
  task automatic move(input logic tms);
    logic d;
    step(tms, ~tdi_o, d);
  endtask
  task automatic to_idle();
    for (int i = 0; i < 5; i++) begin
      move(1'b1);
    end
    move(1'b0);
  endtask
  // scans during busy only when the bench asks
  task automatic load_ir(input logic [4:0] code);
    logic d;
    move(1'b1);
    move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < 5; i++) begin
      step(i == 4, code[i], d);
    end
    move(1'b1);
    move(1'b0);
  endtask
  // 32 bit data shift, ones shifted in, lsb first
  task automatic shift_dr(output logic [31:0] dout);
    logic d;
    dout = 32'h0000_0000;
    move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < 32; i++) begin
      step(i == 31, 1'b1, d);
      dout[i] = d;
    end
    move(1'b1);
    move(1'b0);
  endtask
endmodule // scan_tester
`default_nettype wire

// ==== verification/scan_instruction_decoder_test.sv ====
// self-checking bench of the scan instruction decoder
`timescale 1ns/1ps
`default_nettype none
module scan_instruction_decoder_test;
  localparam logic [31:0] ID_VAL = 32'h1234_5001;  // value arbitrary
  localparam logic [31:0] UC_VAL = 32'hA5C3_0F96;
  localparam scan_decode_pkg::instr_t CODE_TAB [12] = '{
    scan_decode_pkg::EXTEST_CODE, scan_decode_pkg::SAMPLE_CODE,
    scan_decode_pkg::USER_SCAN_A_CODE, scan_decode_pkg::USER_SCAN_B_CODE,
    scan_decode_pkg::INTEST_CODE, scan_decode_pkg::USERCODE_CODE,
    scan_decode_pkg::IDCODE_CODE, scan_decode_pkg::HIGHZ_CODE,
    scan_decode_pkg::STARTUP_CLOCK_INSTR, scan_decode_pkg::BYPASS_CODE, 5'h05, 5'h1E};
  logic        mclk, rstn, tck, tms, tdi, tdo, tdo_oe;
  logic        cfg_busy, cfg_done, src, extest, sample, intest, highz, ua, ub;
  logic        step_p, u_rst, u_upd, u_sh, seen_sh, seen_upd, seen_oe;
  logic [31:0] dout;
  int          n_mismatch, cmp_count, steps;

  scan_instruction_decoder #(.ID_CODE(ID_VAL)) DUT (
    .mclk_i(mclk), .rstn_i(rstn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .cfg_busy_i(cfg_busy), .cfg_done_i(cfg_done),
    .startup_clock_source_i(src), .usercode_i(UC_VAL), .bscan_tdo_i(1'b1),
    .user_tdo_i(1'b0), .extest_o(extest), .sample_o(sample), .intest_o(intest),
    .highz_o(highz), .user_scan_instr_a_o(ua), .user_scan_instr_b_o(ub),
    .startup_step_o(step_p), .user_reset_o(u_rst), .user_update_o(u_upd),
    .user_shift_o(u_sh));
  // released tdo reads as pulled high
  scan_tester far_end (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_oe ? tdo : 1'b1));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // pulse counter and state sightings
  always @(posedge mclk) begin
    if (step_p === 1'b1) steps++;
    if (u_sh === 1'b1) seen_sh = 1'b1;
    if (u_upd === 1'b1) seen_upd = 1'b1;
    if (tdo_oe === 1'b1) seen_oe = 1'b1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // instruction in effect under the configuration state
  function automatic scan_decode_pkg::instr_t eff_of(input scan_decode_pkg::instr_t c,
                                                     input logic busy, input logic done);
    logic listed;
    listed = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (c == CODE_TAB[i]) listed = 1'b1;
    end
    if (!listed) return scan_decode_pkg::BYPASS_CODE;
    if (busy && c != scan_decode_pkg::SAMPLE_CODE) return scan_decode_pkg::BYPASS_CODE;
    if (!done && (c == scan_decode_pkg::USER_SCAN_A_CODE ||
                  c == scan_decode_pkg::USER_SCAN_B_CODE)) return scan_decode_pkg::BYPASS_CODE;
    return c;
  endfunction
  function automatic logic [31:0] dout_of(input scan_decode_pkg::instr_t e);
    case (e)
      scan_decode_pkg::EXTEST_CODE, scan_decode_pkg::SAMPLE_CODE,
      scan_decode_pkg::INTEST_CODE: return 32'hFFFF_FFFF;
      scan_decode_pkg::USER_SCAN_A_CODE, scan_decode_pkg::USER_SCAN_B_CODE: return 32'h0000_0000;
      scan_decode_pkg::IDCODE_CODE: return ID_VAL;
      scan_decode_pkg::USERCODE_CODE: return UC_VAL;
      default: return 32'hFFFF_FFFE;
    endcase
  endfunction

  task automatic set_cfg(input logic busy, input logic done, input logic s);
    @(posedge mclk);
    #1;
    cfg_busy = busy;
    cfg_done = done;
    src = s;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // reset in mid-run drops the held instruction
  task automatic sc_mid_reset();
    set_cfg(1'b0, 1'b1, 1'b1);
    far_end.load_ir(scan_decode_pkg::HIGHZ_CODE);
    chk(32'(highz), 32'h1, "highz before reset");
    rstn = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(32'({highz, u_rst}), 32'h1, "state after mid reset");
    far_end.to_idle();
    far_end.shift_dr(dout);
    chk(dout, ID_VAL, "id after mid reset");
  endtask
  // reset leaves the identification code selected
  task automatic sc_reset_id();
    chk(32'(u_rst), 32'h1, "reset state output");
    far_end.to_idle();
    seen_sh = 1'b0;
    seen_upd = 1'b0;
    seen_oe = 1'b0;
    far_end.shift_dr(dout);
    chk(dout, ID_VAL, "id after reset");
    chk(32'({seen_sh, seen_upd, seen_oe, u_rst}), 32'hE, "shift update mirrors");
  endtask
  // every listed code and two reserved codes under one configuration state
  task automatic sc_codes(input logic busy, input logic done, input logic s);
    scan_decode_pkg::instr_t e;
    set_cfg(busy, done, s);
    for (int i = 0; i < 12; i++) begin
      e = eff_of(CODE_TAB[i], busy, done);
      far_end.load_ir(CODE_TAB[i]);
      chk(32'({extest, sample, intest, highz, ua, ub}),
          32'({e == scan_decode_pkg::EXTEST_CODE, e == scan_decode_pkg::SAMPLE_CODE,
               e == scan_decode_pkg::INTEST_CODE, e == scan_decode_pkg::HIGHZ_CODE,
               e == scan_decode_pkg::USER_SCAN_A_CODE, e == scan_decode_pkg::USER_SCAN_B_CODE}),
          "selects");
      steps = 0;
      far_end.shift_dr(dout);
      chk(dout, dout_of(e), "chain data");
      chk(32'(steps), (e == scan_decode_pkg::STARTUP_CLOCK_INSTR && s) ? 32'd37 : 32'd0,
          "start-up steps");
    end
  endtask

  initial begin
    rstn = 1'b0;
    cfg_busy = 1'b0;
    cfg_done = 1'b0;
    src = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    steps = 0;
    repeat (8) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    sc_reset_id();
    sc_codes(1'b0, 1'b0, 1'b1);
    sc_codes(1'b1, 1'b0, 1'b1);
    sc_codes(1'b0, 1'b1, 1'b1);
    sc_codes(1'b0, 1'b1, 1'b0);
    sc_codes(1'b1, 1'b1, 1'b1);
    sc_mid_reset();
    report_and_stop();
  end
  // hang guard
  initial begin
    #900_000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    report_and_stop();
  end
endmodule // scan_instruction_decoder_test
`default_nettype wire
